// ==== verilog/scan_port_pkg.sv ====
// Package with constants and types for the boundary scan test port.
package scan_port_pkg;

  // Width of the instruction register.
  localparam int IR_WIDTH = 3;
  // Width of the identification register.
  localparam int ID_WIDTH = 32;
  // Default length of the boundary scan register.
  localparam int BSR_LEN = 109;
  // Position of the output bus control cell in the boundary register.
  localparam int OUT_CTRL_BIT = 108;

  // Instruction codes; the values are an arbitrary assignment.
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDREAD = 3'h1;
  localparam logic [2:0] INS_SAMPZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;

  // Pattern captured into the low instruction bits.
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // Identification value; arbitrary neutral value.
  localparam logic [31:0] ID_VALUE = 32'h1234_5679;
  // Number of TMS-high edges that always reach the reset state.
  localparam int RESET_EDGES = 5;
  // Link clock period in ns, and the core clock period in ns.
  localparam int TCK_PERIOD_NS = 200;
  localparam int MCLK_PERIOD_NS = 25;
  // Core cycles per link clock period, rounded down.
  localparam int TCK_CYCLES = TCK_PERIOD_NS / MCLK_PERIOD_NS;

  // Controller states of the sixteen-state sequence.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Synchronised pin samples travelling together.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } pin_sample_t;

endpackage

// ==== verilog/boundary_scan_test_port.sv ====
// Boundary scan test access port sampling the link pins on the core clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) Follows the standard test port architecture.
// (R2) Unused port keeps test clock held low.
// (R3) Data and mode inputs pulled up internally.
// (R4) Powers up in reset without disturbing memory.
// (R5) Mode and data sampled on rising clock.
// (R6) Serial output changes on falling clock.
// (R7) Serial output driven only while shifting.
// (R8) Instruction selects exactly one scan register.
// (R9) Data enters MSB, leaves from LSB.
// (R10) Five mode-high edges reach reset state.
// (R11) Port reset leaves memory operation alone.
// (R12) Power-up reset leaves serial output undriven.
// (R13) Instruction register three bits, loaded serially.
// (R14) Reset presets identification-read instruction.
// (R15) Instruction capture loads binary 01 low.
// (R16) Bypass is a single flip-flop.
// (R17) Bypass instruction clears bypass register.
// (R18) Boundary register covers every ring pin.
// (R19) Boundary register captures ring, then shifts.
// (R20) Three instructions select boundary register.
// (R21) Identification instruction captures fixed 32 bits.
// (R22) New instruction acts only at update.
// (R23) High-impedance sample floats output bus.
// (R24) Controller never loads reserved codes; the code loads any shifted code at update.
// (R25) Control cell drives output bus under external test.
// (R26) Reserved codes select the bypass register.
// (R27) Sixteen-state controller, power-up forces reset.
module boundary_scan_test_port #(
  parameter int BSR_LEN = scan_port_pkg::BSR_LEN // Boundary register length.
) (
  input wire logic mclk_i, // Core clock, 40 MHz.
  input wire logic rst_b_i, // Power-up reset, active low.
  input wire logic tck_i, // Test clock pin.
  input wire logic tms_i, // Mode select pin, pulled up outside.
  input wire logic tdi_i, // Serial data in pin, pulled up outside.
  input wire logic [BSR_LEN-1:0] ring_i, // Pin ring values for capture.
  output logic tdo_o, // Serial data out.
  output logic tdo_oe_o, // Serial output enable, high while driving.
  output logic [BSR_LEN-1:0] ring_drive_o, // Update stage for external test.
  output logic extest_o, // External test is the current instruction.
  output logic qbus_oe_o // Output bus enable from the test port.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, only the second stage is read.
  scan_port_pkg::pin_sample_t sync1_reg; // First stage.
  scan_port_pkg::pin_sample_t sync2_reg; // Second stage.
  logic tck_last_reg; // Previous synchronised clock level.
  logic rise; // Rising link clock edge seen.
  logic fall; // Falling link clock edge seen.

  // Reset brings the mode and data samples up high, as the pull-ups do.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1}; // R3
      sync2_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      tck_last_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
      sync2_reg <= sync1_reg;
      tck_last_reg <= sync2_reg.tck;
    end
  end

  // A clock held low never makes an edge, so the port stays idle.
  assign rise = sync2_reg.tck & ~tck_last_reg; // R5 R2
  assign fall = ~sync2_reg.tck & tck_last_reg; // R6

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine.
  scan_port_pkg::tap_state_t st_reg; // Current state.
  scan_port_pkg::tap_state_t st_next; // Next state.

  // Standard transitions; a steady high mode walks to reset in five edges.
  always_comb
  begin
    st_next = st_reg;
    if (rise)
    begin
      case (st_reg) // R27 R1 R10
        scan_port_pkg::ST_RESET: st_next = sync2_reg.tms ? scan_port_pkg::ST_RESET
                                                         : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_IDLE: st_next = sync2_reg.tms ? scan_port_pkg::ST_SEL_DR
                                                        : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_SEL_DR: st_next = sync2_reg.tms ? scan_port_pkg::ST_SEL_IR
                                                          : scan_port_pkg::ST_CAP_DR;
        scan_port_pkg::ST_CAP_DR, scan_port_pkg::ST_SHIFT_DR:
          st_next = sync2_reg.tms ? scan_port_pkg::ST_EXIT1_DR : scan_port_pkg::ST_SHIFT_DR;
        scan_port_pkg::ST_EXIT1_DR: st_next = sync2_reg.tms ? scan_port_pkg::ST_UPD_DR
                                                            : scan_port_pkg::ST_PAUSE_DR;
        scan_port_pkg::ST_PAUSE_DR: st_next = sync2_reg.tms ? scan_port_pkg::ST_EXIT2_DR
                                                            : scan_port_pkg::ST_PAUSE_DR;
        scan_port_pkg::ST_EXIT2_DR: st_next = sync2_reg.tms ? scan_port_pkg::ST_UPD_DR
                                                            : scan_port_pkg::ST_SHIFT_DR;
        scan_port_pkg::ST_UPD_DR, scan_port_pkg::ST_UPD_IR:
          st_next = sync2_reg.tms ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_SEL_IR: st_next = sync2_reg.tms ? scan_port_pkg::ST_RESET
                                                          : scan_port_pkg::ST_CAP_IR;
        scan_port_pkg::ST_CAP_IR, scan_port_pkg::ST_SHIFT_IR:
          st_next = sync2_reg.tms ? scan_port_pkg::ST_EXIT1_IR : scan_port_pkg::ST_SHIFT_IR;
        scan_port_pkg::ST_EXIT1_IR: st_next = sync2_reg.tms ? scan_port_pkg::ST_UPD_IR
                                                            : scan_port_pkg::ST_PAUSE_IR;
        scan_port_pkg::ST_PAUSE_IR: st_next = sync2_reg.tms ? scan_port_pkg::ST_EXIT2_IR
                                                            : scan_port_pkg::ST_PAUSE_IR;
        scan_port_pkg::ST_EXIT2_IR: st_next = sync2_reg.tms ? scan_port_pkg::ST_UPD_IR
                                                            : scan_port_pkg::ST_SHIFT_IR;
        default: st_next = scan_port_pkg::ST_RESET;
      endcase
    end
  end

  // Power-up reset forces the reset state; memory logic is never touched.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_reg <= scan_port_pkg::ST_RESET; // R4 R27 R11
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan registers.
  logic [2:0] ir_shift_reg, ir_shift_next; // Instruction shift stage.
  logic [2:0] ir_reg, ir_next; // Current instruction.
  logic byp_reg, byp_next; // Bypass stage.
  logic [31:0] id_reg, id_next; // Identification shift register.
  logic [BSR_LEN-1:0] bsr_reg, bsr_next; // Boundary shift register.
  logic [BSR_LEN-1:0] upd_reg, upd_next; // Boundary update latches.
  logic tdo_reg, tdo_next; // Serial output.
  logic oe_reg, oe_next; // Serial output enable.
  logic sel_bsr; // Boundary register selected.
  logic sel_id; // Identification register selected.
  logic serial_bit; // Bit presented toward the output.

  // Boundary register is used by the three ring instructions.
  function automatic logic uses_bsr(input logic [2:0] ins);
    uses_bsr = (ins == scan_port_pkg::INS_EXTEST) || (ins == scan_port_pkg::INS_SAMPLE)
            || (ins == scan_port_pkg::INS_SAMPZ);
  endfunction

  assign sel_bsr = uses_bsr(ir_reg); // R20 R8
  assign sel_id = (ir_reg == scan_port_pkg::INS_IDREAD);

  // One register feeds the output; reserved codes fall through to bypass.
  always_comb
  begin
    if (st_reg == scan_port_pkg::ST_SHIFT_IR)
      serial_bit = ir_shift_reg[0];
    else if (sel_bsr)
      serial_bit = bsr_reg[0]; // R9
    else if (sel_id)
      serial_bit = id_reg[0];
    else
      serial_bit = byp_reg; // R26 R16
  end

  // Capture, shift and update happen only on a rising link clock edge.
  always_comb
  begin
    ir_shift_next = ir_shift_reg;
    ir_next = ir_reg;
    byp_next = byp_reg;
    id_next = id_reg;
    bsr_next = bsr_reg;
    upd_next = upd_reg;
    if (rise)
    begin
      case (st_reg)
        scan_port_pkg::ST_RESET:
        begin
          ir_next = scan_port_pkg::INS_IDREAD; // R14
          upd_next[scan_port_pkg::OUT_CTRL_BIT] = 1'b0;
        end
        scan_port_pkg::ST_CAP_IR:
          ir_shift_next = {ir_reg[2], scan_port_pkg::IR_CAPTURE}; // R15
        scan_port_pkg::ST_SHIFT_IR:
          ir_shift_next = {sync2_reg.tdi, ir_shift_reg[2:1]}; // R13 R9
        scan_port_pkg::ST_UPD_IR:
          ir_next = ir_shift_reg; // R22
        scan_port_pkg::ST_CAP_DR:
        begin
          byp_next = 1'b0; // R17
          if (sel_id)
            id_next = scan_port_pkg::ID_VALUE; // R21
          if (sel_bsr)
            bsr_next = ring_i; // R19 R18
        end
        scan_port_pkg::ST_SHIFT_DR:
        begin
          byp_next = sync2_reg.tdi; // R16
          if (sel_id)
            id_next = {sync2_reg.tdi, id_reg[31:1]}; // R9
          if (sel_bsr)
            bsr_next = {sync2_reg.tdi, bsr_reg[BSR_LEN-1:1]}; // R19
        end
        scan_port_pkg::ST_UPD_DR:
          if (sel_bsr && ir_reg != scan_port_pkg::INS_SAMPZ)
            upd_next = bsr_reg; // R25
        default: ;
      endcase
      // Entering reset presets the instruction at once, so that a mode reset
      // from any state behaves like power-up without waiting a further edge.
      if (st_next == scan_port_pkg::ST_RESET)
      begin
        ir_next = scan_port_pkg::INS_IDREAD; // R14
        upd_next[scan_port_pkg::OUT_CTRL_BIT] = 1'b0;
      end
    end
  end

  // Output changes on the falling edge; enabled only in shift states.
  always_comb
  begin
    tdo_next = tdo_reg;
    oe_next = oe_reg;
    if (fall)
    begin
      oe_next = (st_reg == scan_port_pkg::ST_SHIFT_DR)
             || (st_reg == scan_port_pkg::ST_SHIFT_IR); // R7
      tdo_next = oe_next ? serial_bit : 1'b0; // R6
    end
  end

  // Register all scan state; power-up leaves the output undriven.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ir_shift_reg <= '0;
      ir_reg <= scan_port_pkg::INS_IDREAD; // R14
      byp_reg <= 1'b0;
      id_reg <= '0;
      bsr_reg <= '0;
      upd_reg <= '0;
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0; // R12
    end
    else
    begin
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
      byp_reg <= byp_next;
      id_reg <= id_next;
      bsr_reg <= bsr_next;
      upd_reg <= upd_next;
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output bus control, registered so each output comes from a flop.
  logic extest_reg; // External test active.
  logic qoe_reg; // Output bus enable.

  // High-impedance sample floats the bus until a new instruction arrives.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      extest_reg <= 1'b0;
      qoe_reg <= 1'b1;
    end
    else
    begin
      extest_reg <= (ir_reg == scan_port_pkg::INS_EXTEST);
      qoe_reg <= (ir_reg == scan_port_pkg::INS_SAMPZ) ? 1'b0 // R23
               : (ir_reg == scan_port_pkg::INS_EXTEST)
                 ? upd_reg[scan_port_pkg::OUT_CTRL_BIT] : 1'b1; // R25
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_o = oe_reg;
  assign ring_drive_o = upd_reg;
  assign extest_o = extest_reg;
  assign qbus_oe_o = qoe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  logic [2:0] hi_cnt_reg; // Consecutive rising edges with mode high.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hi_cnt_reg <= '0;
    else if (rise)
      hi_cnt_reg <= !sync2_reg.tms ? 3'h0 : (hi_cnt_reg == 3'h5 ? 3'h5 : hi_cnt_reg + 3'h1);
  end

  property p_reset_five;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (hi_cnt_reg == 3'h5) |-> (st_reg == scan_port_pkg::ST_RESET);
  endproperty
  a_reset_five: assert property (p_reset_five) else $error("five high edges missed reset"); // R10

  property p_tdo_on_fall;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !fall |=> $stable(tdo_reg) && $stable(oe_reg);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("output moved off fall"); // R6

  property p_oe_shift;
    @(posedge mclk_i) disable iff (!rst_b_i)
      fall |=> oe_reg == ($past(st_reg) == scan_port_pkg::ST_SHIFT_DR
                       || $past(st_reg) == scan_port_pkg::ST_SHIFT_IR);
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("output enable outside shift"); // R7

  property p_reset_ir;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (rise && st_next == scan_port_pkg::ST_RESET) |=> ir_reg == scan_port_pkg::INS_IDREAD;
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset did not preset instruction"); // R14

  property p_cap_ir;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (rise && st_reg == scan_port_pkg::ST_CAP_IR) |=> ir_shift_reg[1:0] == 2'h1;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture pattern wrong"); // R15

  property p_ir_hold;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !(rise && (st_reg == scan_port_pkg::ST_UPD_IR || st_next == scan_port_pkg::ST_RESET))
        |=> $stable(ir_reg);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed off update"); // R22

  property p_id_cap;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (rise && sel_id && st_reg == scan_port_pkg::ST_CAP_DR)
        |=> id_reg == scan_port_pkg::ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("id value not captured"); // R21

  property p_byp_clr;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (rise && st_reg == scan_port_pkg::ST_CAP_DR) |=> !byp_reg;
  endproperty
  a_byp_clr: assert property (p_byp_clr) else $error("bypass not cleared"); // R17

  property p_sampz;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (ir_reg == scan_port_pkg::INS_SAMPZ) |=> !qoe_reg;
  endproperty
  a_sampz: assert property (p_sampz) else $error("bus not floated"); // R23

endmodule // boundary_scan_test_port

// ==== verif/scan_controller_model.sv ====
// Behavioural test controller that clocks the scan port from outside.
`timescale 1ns/1ps

module scan_controller_model (
  input wire logic mclk_i, // Core clock, used only to pace the link clock.
  input wire logic tdo_i, // Serial data from the port.
  input wire logic tdo_oe_i, // High while the port drives serial data.
  output logic tck_o, // Link clock, still low between frames.
  output logic tms_o, // Mode select to the port.
  output logic tdi_o // Serial data to the port.
);

  // Last level seen on the serial data line.
  logic line_last = 1'b0;
  // An undriven line shows the inverse of its last level, so stale data never passes.
  wire logic tdo_line = tdo_oe_i ? tdo_i : ~line_last;

  ////////////////////////////////////////////////////////////////////////////////
  // The link clock rests low so the port is never clocked between frames.
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One link clock of 200 ns; serial data is read just before the rise.
  task automatic bit_clk(input logic m, input logic d, output logic o, output logic oe);
    tms_o = m;
    tdi_o = d;
    repeat (4) @(posedge mclk_i);
    #1;
    o = tdo_line;
    oe = tdo_oe_i;
    line_last = tdo_line;
    tck_o = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    tck_o = 1'b0;
  endtask

endmodule // scan_controller_model

// ==== verif/boundary_scan_test_port_bench.sv ====
// Self-checking bench for the boundary scan test port.
`timescale 1ns/1ps

module boundary_scan_test_port_bench;

  localparam int N = scan_port_pkg::BSR_LEN; // Boundary register length.
  localparam int LIMIT = 20000; // Core cycles allowed; the run needs about 4500.
  logic mclk_i = 1'b0; // Core clock.
  logic rst_b_i = 1'b0; // Power-up reset, active low.
  logic tck, tms, tdi; // Link pins from the controller model.
  logic tdo, tdo_oe, extest, qbus_oe; // Port outputs.
  logic [N-1:0] ring_drive; // Update latches of the boundary register.
  logic [N-1:0] pat = N'({5{24'hC3_96A5}}); // Ring values; bit 108 is high.
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and the two instances.
  always #12.5 mclk_i = ~mclk_i;

  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      finish_test();
    end
  end

  boundary_scan_test_port #(.BSR_LEN(N)) i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .ring_i(pat), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .ring_drive_o(ring_drive), .extest_o(extest), .qbus_oe_o(qbus_oe));

  scan_controller_model i_ctl (.mclk_i(mclk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic fail(input string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One link clock whose serial output is not needed.
  task automatic clk(input logic m);
    logic o;
    logic oe;
    i_ctl.bit_clk(m, 1'b1, o, oe);
  endtask

  // From Idle: load a 3-bit code LSB first, update, and return to Idle.
  task automatic ir_load(input logic [2:0] code, output logic [2:0] cap);
    logic oe;
    clk(1);
    clk(1);
    clk(0);
    clk(0);
    for (int i = 0; i < 3; i++)
      i_ctl.bit_clk(i == 2, code[i], cap[i], oe);
    clk(1);
    clk(0);
    repeat (8) @(posedge mclk_i);
    #1;
  endtask

  // From Idle: capture, shift n bits, update, return to Idle.
  task automatic dr_scan(input int n, input logic [N-1:0] din, output logic [N-1:0] dout);
    logic oe;
    int bad;
    bad = 0;
    dout = '0;
    clk(1);
    clk(0);
    clk(0);
    for (int i = 0; i < n; i++)
    begin
      i_ctl.bit_clk(i == n - 1, din[i], dout[i], oe);
      bad += int'(oe !== 1'b1);
    end
    clk(1);
    clk(0);
    repeat (8) @(posedge mclk_i);
    #1;
    checked++;
    if (bad != 0 || tdo_oe !== 1'b0) fail("serial output enable outside shifting");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic s_reset_state();
    checked++;
    if (tdo_oe !== 1'b0 || qbus_oe !== 1'b1 || extest !== 1'b0) fail("reset outputs");
    checked++;
    if (ring_drive !== '0) fail("update latches after reset");
    clk(0);
  endtask

  // Identification value read out LSB first after a reset.
  task automatic s_idcode();
    logic [N-1:0] d;
    dr_scan(32, '0, d);
    checked++;
    if (d[31:0] !== scan_port_pkg::ID_VALUE) fail("identification value");
  endtask

  // Bypass gives a one-stage path that starts cleared; only the bypass code itself is loaded.
  task automatic s_bypass();
    logic [7:0] pats[2] = '{8'hB5, 8'h4A};
    logic [2:0] cap;
    logic [N-1:0] din;
    logic [N-1:0] d;
    foreach (pats[k])
    begin
      ir_load(scan_port_pkg::INS_BYPASS, cap);
      checked++;
      if (cap[1:0] !== scan_port_pkg::IR_CAPTURE) fail("instruction capture pattern");
      din = N'(pats[k]);
      dr_scan(8, din, d);
      checked++;
      if (d[7:0] !== {din[6:0], 1'b0}) fail("bypass path");
    end
  endtask

  // Ring capture under the three boundary instructions, preload and bus control.
  task automatic s_boundary();
    logic [2:0] cap;
    logic [N-1:0] d;
    ir_load(scan_port_pkg::INS_SAMPLE, cap);
    dr_scan(N, ~pat, d);
    checked++;
    if (d !== pat || ring_drive !== ~pat) fail("sample capture or preload");
    ir_load(scan_port_pkg::INS_EXTEST, cap);
    checked++;
    if (extest !== 1'b1 || qbus_oe !== 1'b0) fail("control cell low under extest");
    dr_scan(N, pat, d);
    checked++;
    if (d !== pat || qbus_oe !== 1'b1) fail("control cell high under extest");
    ir_load(scan_port_pkg::INS_SAMPZ, cap);
    checked++;
    if (qbus_oe !== 1'b0 || extest !== 1'b0) fail("output bus not floated");
    dr_scan(N, ~pat, d);
    checked++;
    if (d !== pat || ring_drive !== pat || qbus_oe !== 1'b0) fail("sample z scan");
  endtask

  // Five mode-high edges from mid-shift reach reset and restore identification read.
  task automatic s_tms_reset();
    clk(1);
    clk(0);
    clk(0);
    repeat (5) clk(1);
    repeat (8) @(posedge mclk_i);
    #1;
    checked++;
    if (qbus_oe !== 1'b1 || tdo_oe !== 1'b0) fail("state after mode reset");
    clk(0);
    s_idcode();
  endtask

  // A power-up reset in mid-run forces the reset state and the identification read.
  task automatic s_power_reset();
    logic [2:0] cap;
    ir_load(scan_port_pkg::INS_SAMPZ, cap);
    @(posedge mclk_i);
    #1;
    rst_b_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    checked++;
    if (qbus_oe !== 1'b1 || tdo_oe !== 1'b0) fail("outputs after power-up reset");
    clk(0);
    s_idcode();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    s_reset_state();
    s_idcode();
    s_bypass();
    s_boundary();
    s_tms_reset();
    s_power_reset();
    finish_test();
  end

endmodule // boundary_scan_test_port_bench
